// File: core/bst_map.svh
`ifndef BST_MAP_SVH
`define BST_MAP_SVH

// ----------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------
`define BST_IR_W_DEF 4
`define BST_IR_MIN_W 2
`define BST_IR_CAPTURE 4'h1
`define BST_OP_BYPASS 4'hF
`define BST_OP_IDCODE 4'h2

// ----------------------------------------------------------------------
// identification register
// ----------------------------------------------------------------------
`define BST_ID_W 32
// arbitrary neutral identity, lsb must stay 1
`define BST_ID_DEF 32'h0000_0001

// ----------------------------------------------------------------------
// reset values and pin defaults
// ----------------------------------------------------------------------
`define BST_BYP_CAPTURE 1'b0
`define BST_PULL_LEVEL 1'b1
`define BST_SYNC_STAGES 2

`endif

// File: core/bst_pkg.sv
`default_nettype none
package bst_pkg;

   // ----------------------------------------------------------------------
   // tap controller states
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      BST_TLR  = 4'b0000,
      BST_RTI  = 4'b0001,
      BST_SDRS = 4'b0010,
      BST_CDR  = 4'b0011,
      BST_SDR  = 4'b0100,
      BST_E1DR = 4'b0101,
      BST_PDR  = 4'b0110,
      BST_E2DR = 4'b0111,
      BST_UDR  = 4'b1000,
      BST_SIRS = 4'b1001,
      BST_CIR  = 4'b1010,
      BST_SIR  = 4'b1011,
      BST_E1IR = 4'b1100,
      BST_PIR  = 4'b1101,
      BST_E2IR = 4'b1110,
      BST_UIR  = 4'b1111
   } bst_state_t;

endpackage

`default_nettype wire

// File: core/bst_sync.sv
`timescale 1ns/1ps
`default_nettype none

module bst_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   initial begin
      if (W < 1) begin
         $error("bst_sync: width must be at least one");
      end
   end

   // first stage feeds only the second stage
   always_comb begin
      meta_nxt = d_i;
      q_nxt = meta_r;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         q_r <= q_nxt;
      end
   end

   assign q_o = q_r;

endmodule

`default_nettype wire

// File: core/bst_tap.sv
`timescale 1ns/1ps
`default_nettype none
`include "bst_map.svh"

module bst_tap #(
   parameter int IR_W = `BST_IR_W_DEF,
   parameter logic [`BST_ID_W-1:0] ID_VALUE = `BST_ID_DEF
) (
   // system clock and power-on reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // test port, link clock domain
   input wire logic tck_i,
   input wire logic trst_n_i,
   input wire logic tms_i,
   input wire logic tms_drv_i,
   input wire logic tdi_i,
   input wire logic tdi_drv_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   // system side status
   output logic [IR_W-1:0] ir_o,
   output logic ir_upd_o,
   output logic tap_reset_o
);

   // ----------------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------------
   initial begin
      if (IR_W < `BST_IR_MIN_W) begin
         $error("bst_tap: instruction register too narrow");
      end
      if (ID_VALUE[0] != 1'b1) begin
         $error("bst_tap: identification value must have lsb set");
      end
   end

   localparam logic [IR_W-1:0] IR_BYPASS = IR_W'(`BST_OP_BYPASS);
   localparam logic [IR_W-1:0] IR_IDCODE = IR_W'(`BST_OP_IDCODE);
   localparam logic [IR_W-1:0] IR_CAPT = IR_W'(`BST_IR_CAPTURE);

   function automatic logic sel_id(input logic [IR_W-1:0] ir);
      sel_id = (ir == IR_IDCODE);
   endfunction

   // ----------------------------------------------------------------------
   // test domain reset
   // ----------------------------------------------------------------------
   // power-on reset and test reset both clear the tap without a clock edge
   logic tap_rst_n;
   assign tap_rst_n = resetn_i & trst_n_i;

   // ----------------------------------------------------------------------
   // pin pull-ups
   // ----------------------------------------------------------------------
   logic tms_pin;
   logic tdi_pin;
   assign tms_pin = tms_drv_i ? tms_i : `BST_PULL_LEVEL;
   assign tdi_pin = tdi_drv_i ? tdi_i : `BST_PULL_LEVEL;

   // ----------------------------------------------------------------------
   // tap controller and shift registers, rising test clock
   // ----------------------------------------------------------------------
   bst_pkg::bst_state_t state_r;
   bst_pkg::bst_state_t state_nxt;
   logic [IR_W-1:0] ir_sr_r;
   logic [IR_W-1:0] ir_sr_nxt;
   logic [IR_W-1:0] ir_r;
   logic [IR_W-1:0] ir_nxt;
   logic [`BST_ID_W-1:0] id_sr_r;
   logic [`BST_ID_W-1:0] id_sr_nxt;
   logic byp_r;
   logic byp_nxt;
   logic upd_tgl_r;
   logic upd_tgl_nxt;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         bst_pkg::BST_TLR: begin
            state_nxt = tms_pin ? bst_pkg::BST_TLR : bst_pkg::BST_RTI;
         end
         bst_pkg::BST_RTI: begin
            state_nxt = tms_pin ? bst_pkg::BST_SDRS : bst_pkg::BST_RTI;
         end
         bst_pkg::BST_SDRS: begin
            state_nxt = tms_pin ? bst_pkg::BST_SIRS : bst_pkg::BST_CDR;
         end
         bst_pkg::BST_CDR: begin
            state_nxt = tms_pin ? bst_pkg::BST_E1DR : bst_pkg::BST_SDR;
         end
         bst_pkg::BST_SDR: begin
            state_nxt = tms_pin ? bst_pkg::BST_E1DR : bst_pkg::BST_SDR;
         end
         bst_pkg::BST_E1DR: begin
            state_nxt = tms_pin ? bst_pkg::BST_UDR : bst_pkg::BST_PDR;
         end
         bst_pkg::BST_PDR: begin
            state_nxt = tms_pin ? bst_pkg::BST_E2DR : bst_pkg::BST_PDR;
         end
         bst_pkg::BST_E2DR: begin
            state_nxt = tms_pin ? bst_pkg::BST_UDR : bst_pkg::BST_SDR;
         end
         bst_pkg::BST_UDR: begin
            state_nxt = tms_pin ? bst_pkg::BST_SDRS : bst_pkg::BST_RTI;
         end
         bst_pkg::BST_SIRS: begin
            state_nxt = tms_pin ? bst_pkg::BST_TLR : bst_pkg::BST_CIR;
         end
         bst_pkg::BST_CIR: begin
            state_nxt = tms_pin ? bst_pkg::BST_E1IR : bst_pkg::BST_SIR;
         end
         bst_pkg::BST_SIR: begin
            state_nxt = tms_pin ? bst_pkg::BST_E1IR : bst_pkg::BST_SIR;
         end
         bst_pkg::BST_E1IR: begin
            state_nxt = tms_pin ? bst_pkg::BST_UIR : bst_pkg::BST_PIR;
         end
         bst_pkg::BST_PIR: begin
            state_nxt = tms_pin ? bst_pkg::BST_E2IR : bst_pkg::BST_PIR;
         end
         bst_pkg::BST_E2IR: begin
            state_nxt = tms_pin ? bst_pkg::BST_UIR : bst_pkg::BST_SIR;
         end
         bst_pkg::BST_UIR: begin
            state_nxt = tms_pin ? bst_pkg::BST_SDRS : bst_pkg::BST_RTI;
         end
         default: begin
            state_nxt = bst_pkg::BST_TLR;
         end
      endcase
   end

   always_comb begin
      ir_sr_nxt = ir_sr_r;
      ir_nxt = ir_r;
      id_sr_nxt = id_sr_r;
      byp_nxt = byp_r;
      upd_tgl_nxt = upd_tgl_r;
      case (state_r)
         bst_pkg::BST_TLR: begin
            ir_nxt = IR_BYPASS;
         end
         bst_pkg::BST_CIR: begin
            ir_sr_nxt = IR_CAPT;
         end
         bst_pkg::BST_SIR: begin
            ir_sr_nxt = {tdi_pin, ir_sr_r[IR_W-1:1]};
         end
         bst_pkg::BST_UIR: begin
            ir_nxt = ir_sr_r;
            upd_tgl_nxt = ~upd_tgl_r;
         end
         bst_pkg::BST_CDR: begin
            if (sel_id(ir_r)) begin
               id_sr_nxt = ID_VALUE;
            end else begin
               byp_nxt = `BST_BYP_CAPTURE;
            end
         end
         bst_pkg::BST_SDR: begin
            // every instruction but the identity one falls to bypass
            if (sel_id(ir_r)) begin
               id_sr_nxt = {tdi_pin, id_sr_r[`BST_ID_W-1:1]};
            end else begin
               byp_nxt = tdi_pin;
            end
         end
         default: begin
            ir_nxt = ir_r;
         end
      endcase
   end

   always_ff @(posedge tck_i or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         state_r <= bst_pkg::BST_TLR;
         ir_sr_r <= IR_CAPT;
         ir_r <= IR_BYPASS;
         id_sr_r <= `BST_ID_DEF;
         byp_r <= `BST_BYP_CAPTURE;
         upd_tgl_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         ir_sr_r <= ir_sr_nxt;
         ir_r <= ir_nxt;
         id_sr_r <= id_sr_nxt;
         byp_r <= byp_nxt;
         upd_tgl_r <= upd_tgl_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // serial output, falling test clock
   // ----------------------------------------------------------------------
   logic tdo_r;
   logic tdo_nxt;
   logic tdo_oe_r;
   logic tdo_oe_nxt;

   always_comb begin
      tdo_oe_nxt = (state_r == bst_pkg::BST_SIR) || (state_r == bst_pkg::BST_SDR);
      if (state_r == bst_pkg::BST_SIR) begin
         tdo_nxt = ir_sr_r[0];
      end else if (sel_id(ir_r)) begin
         tdo_nxt = id_sr_r[0];
      end else begin
         tdo_nxt = byp_r;
      end
   end

   // half a cycle of setup for the far end's rising sample
   always_ff @(negedge tck_i or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         tdo_r <= 1'b0;
         tdo_oe_r <= 1'b0;
      end else begin
         tdo_r <= tdo_nxt;
         tdo_oe_r <= tdo_oe_nxt;
      end
   end

   assign tdo_o = tdo_r;
   assign tdo_oe_o = tdo_oe_r;

   // ----------------------------------------------------------------------
   // crossing to the system clock
   // ----------------------------------------------------------------------
   // toggle marks an instruction update; ir_r then holds still for several
   // test clocks, so the word is stable when the system side samples it
   logic tlr_lvl;
   logic [1:0] sync_q;
   assign tlr_lvl = (state_r == bst_pkg::BST_TLR);

   bst_sync #(
      .W(2)
   ) u_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .d_i({~tlr_lvl, upd_tgl_r}), // sync clears to zero, so carry not-in-reset
      .q_o(sync_q)
   );

   logic tgl_seen_r;
   logic tgl_seen_nxt;
   logic [IR_W-1:0] ir_sys_r;
   logic [IR_W-1:0] ir_sys_nxt;
   logic upd_r;
   logic upd_nxt;
   logic rst_sys_r;
   logic rst_sys_nxt;

   always_comb begin
      tgl_seen_nxt = sync_q[0];
      // a test reset clears the toggle too; that edge is no update
      upd_nxt = (sync_q[0] ^ tgl_seen_r) & sync_q[1];
      ir_sys_nxt = ir_sys_r;
      if (upd_nxt) begin
         ir_sys_nxt = ir_r;
      end
      rst_sys_nxt = ~sync_q[1];
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tgl_seen_r <= 1'b0;
         ir_sys_r <= IR_BYPASS;
         upd_r <= 1'b0;
         rst_sys_r <= 1'b1;
      end else begin
         tgl_seen_r <= tgl_seen_nxt;
         ir_sys_r <= ir_sys_nxt;
         upd_r <= upd_nxt;
         rst_sys_r <= rst_sys_nxt;
      end
   end

   assign ir_o = ir_sys_r;
   assign ir_upd_o = upd_r;
   assign tap_reset_o = rst_sys_r;

endmodule

`default_nettype wire

// File: testbench/bst_tap_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "bst_map.svh"
module bst_tap_sva #(
   parameter int IR_W = 4
) (
   // clocks and resets
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic tck_i,
   input wire logic trst_n_i,
   // link
   input wire logic tms_i,
   input wire logic tms_drv_i,
   input wire logic tdi_i,
   input wire logic tdi_drv_i,
   input wire logic tdo_o,
   input wire logic tdo_oe_o,
   // system side
   input wire logic [IR_W-1:0] ir_o,
   input wire logic ir_upd_o,
   input wire logic tap_reset_o
);
   // -----
   // link and system side
   // -----
   logic tms_eff;
   logic tap_rstn;
   logic tdo_rise_r;
   logic oe_rise_r;
   assign tms_eff = tms_drv_i ? tms_i : 1'h1;
   assign tap_rstn = resetn_i && trst_n_i;
   // value held at the rise; any change before the fall is a fault
   always_ff @(posedge tck_i) begin
      tdo_rise_r <= tdo_o;
      oe_rise_r <= tdo_oe_o;
   end
   sequence s_ones5;
      tms_eff [*5];
   endsequence
   sequence s_to_sir;
      s_ones5 ##1 !tms_eff ##1 tms_eff [*2] ##1 !tms_eff [*2];
   endsequence
   sequence s_to_sdr;
      s_ones5 ##1 !tms_eff ##1 tms_eff ##1 !tms_eff [*2];
   endsequence
   a_tdo_on_fall: assert property (@(negedge tck_i) disable iff (!tap_rstn)
      tdo_o == tdo_rise_r && tdo_oe_o == oe_rise_r) else $error("tdo moved off a falling edge");
   a_oe_exit_shift: assert property (@(posedge tck_i) disable iff (!tap_rstn)
      tdo_oe_o && tms_eff |=> !tdo_oe_o) else $error("tdo still driven after shift");
   a_oe_tlr_off: assert property (@(posedge tck_i) disable iff (!tap_rstn)
      s_ones5 |=> !tdo_oe_o) else $error("tdo driven after five high tms");
   a_tap_reset_level: assert property (@(posedge tck_i) disable iff (!tap_rstn)
      tms_eff [*8] |-> tap_reset_o) else $error("tap reset flag low after high tms");
   a_ir_capture: assert property (@(posedge tck_i) disable iff (!tap_rstn)
      s_to_sir |=> tdo_oe_o && tdo_o) else $error("ir capture bit wrong");
   a_dr_default: assert property (@(posedge tck_i) disable iff (!tap_rstn)
      s_to_sdr |=> tdo_oe_o && !tdo_o) else $error("default path not bypass");
   a_trst_now: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !trst_n_i |-> !tdo_oe_o && !tdo_o) else $error("tdo active in test reset");
   a_por_state: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $rose(resetn_i) |-> tap_reset_o && ir_o == `BST_OP_BYPASS) else $error("bad power-up state");
   a_upd_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ir_upd_o |=> !ir_upd_o) else $error("update pulse too long");
   a_upd_not_tlr: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ir_upd_o |-> !tap_reset_o) else $error("update while in reset state");
endmodule
bind bst_tap bst_tap_sva #(.IR_W(IR_W)) u_sva (.clk_i(clk_i), .resetn_i(resetn_i),
   .tck_i(tck_i), .trst_n_i(trst_n_i), .tms_i(tms_i), .tms_drv_i(tms_drv_i), .tdi_i(tdi_i),
   .tdi_drv_i(tdi_drv_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .ir_o(ir_o),
   .ir_upd_o(ir_upd_o), .tap_reset_o(tap_reset_o));
`default_nettype wire

// File: testbench/bst_tester.sv
`timescale 1ns/1ps
`default_nettype none
module bst_tester (
   // link clock
   output logic tck_o,
   // mode and data
   output logic tms_o,
   output logic tms_drv_o,
   output logic tdi_o,
   output logic tdi_drv_o,
   input wire logic tdo_i
);
   // -----
   // test controller
   // -----
   // clock idles low between frames; tdi released between frames
   initial begin
      tck_o = 1'h0;
      tms_o = 1'h1;
      tms_drv_o = 1'h1;
      tdi_o = 1'h0;
      tdi_drv_o = 1'h0;
   end
   task automatic tick(input logic m, input logic d, output logic o);
      tms_o = m;
      // tdi is only driven inside a scan; a released line keeps its own level
      if (tdi_drv_o) tdi_o = d;
      #80 tck_o = 1'h1;
      o = tdo_i;
      #80 tck_o = 1'h0;
   endtask
   task automatic reset5();
      logic o;
      repeat (5) tick(1'h1, 1'h0, o);
      tick(1'h0, 1'h0, o);
   endtask
   // floating tms driven to the wrong level; only the pull-up may win
   task automatic float5();
      logic o;
      tms_drv_o = 1'h0;
      repeat (5) tick(1'h0, 1'h0, o);
      tms_drv_o = 1'h1;
   endtask
   task automatic scan(input logic ir, input logic [31:0] din, output logic [31:0] dout);
      logic o;
      int i;
      dout = 32'h0;
      tdi_drv_o = 1'h1;
      tick(1'h1, 1'h0, o);
      if (ir) tick(1'h1, 1'h0, o);
      tick(1'h0, 1'h0, o);
      tick(1'h0, 1'h0, o);
      for (i = 0; i < (ir ? 4 : 32); i++) begin
         tick(i == (ir ? 3 : 31), din[i], o);
         dout[i] = o;
      end
      tick(1'h1, 1'h0, o);
      tick(1'h0, 1'h0, o);
      tdi_drv_o = 1'h0;
      tdi_o = ~tdi_o;
   endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bst_map.svh"
module tb;
   // -----
   // clocks, design and tester
   // -----
   // arbitrary identity, lsb kept at one
   localparam logic [31:0] ID = 32'h5A5A_C3C5;
   typedef struct {logic [3:0] op; logic [31:0] din; logic [31:0] exp;} bst_row_t;
   bst_row_t rows [3] = '{'{`BST_OP_IDCODE, 32'hFFFF_0000, ID},
      '{`BST_OP_BYPASS, 32'h8000_A5C3, 32'h0001_4B86}, '{4'h5, 32'h1234_5678, 32'h2468_ACF0}};
   logic clk_i = 1'h0;
   logic resetn_i = 1'h0;
   logic trst_n_i = 1'h1;
   logic tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe, ir_upd, tap_reset;
   logic [3:0] ir;
   logic tdo_line;
   // nothing pulls tdo, so a released line shows the inverse of its last level
   assign tdo_line = tdo_oe ? tdo : ~tdo;
   int failures = 0;
   int check_count = 0;
   always #50 clk_i = ~clk_i;
   bst_tap #(.ID_VALUE(ID)) uut (.clk_i(clk_i), .resetn_i(resetn_i), .tck_i(tck),
      .trst_n_i(trst_n_i), .tms_i(tms), .tms_drv_i(tms_drv), .tdi_i(tdi), .tdi_drv_i(tdi_drv),
      .tdo_o(tdo), .tdo_oe_o(tdo_oe), .ir_o(ir), .ir_upd_o(ir_upd), .tap_reset_o(tap_reset));
   bst_tester tst (.tck_o(tck), .tms_o(tms), .tms_drv_o(tms_drv), .tdi_o(tdi),
      .tdi_drv_o(tdi_drv), .tdo_i(tdo_line));
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (exp !== got) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // -----
   // tests
   // -----
   initial begin
      logic [31:0] o;
      int r;
      int k;
      logic t;
      tst.tick(1'h1, 1'h0, t);
      repeat (16) @(negedge clk_i);
      resetn_i = 1'h1;
      @(negedge clk_i);
      check("tap_reset_o", 32'h1, {31'h0, tap_reset});
      check("ir_o", {28'h0, `BST_OP_BYPASS}, {28'h0, ir});
      tst.reset5();
      tst.scan(1'h0, 32'h0000_00F1, o);
      check("bypass default", 32'h0000_01E2, o);
      $display("test reset done");
      for (r = 0; r < 3; r++) begin
         tst.reset5();
         tst.scan(1'h1, {28'h0, rows[r].op}, o);
         check("ir capture", {28'h0, `BST_IR_CAPTURE}, {28'h0, o[3:0]});
         for (k = 0; k < 40 && ir_upd !== 1'h1; k++) @(negedge clk_i);
         check("ir_upd_o", 32'h1, {31'h0, ir_upd});
         check("ir_o", {28'h0, rows[r].op}, {28'h0, ir});
         tst.scan(1'h0, rows[r].din, o);
         check("dr out", rows[r].exp, o);
         $display("test row %0d done", r);
      end
      tst.tick(1'h1, 1'h0, t);
      tst.tick(1'h0, 1'h0, t);
      tst.tick(1'h0, 1'h0, t);
      #1 check("oe in shift", 32'h1, {31'h0, tdo_oe});
      @(negedge clk_i) trst_n_i = 1'h0;
      #1 check("oe at trst", 32'h0, {31'h0, tdo_oe});
      @(negedge clk_i) trst_n_i = 1'h1;
      tst.tick(1'h0, 1'h0, t);
      repeat (8) @(negedge clk_i);
      check("tap_reset_o idle", 32'h0, {31'h0, tap_reset});
      check("ir_o after trst", {28'h0, rows[2].op}, {28'h0, ir});
      $display("test trst done");
      tst.float5();
      repeat (8) @(negedge clk_i);
      check("tap_reset_o float", 32'h1, {31'h0, tap_reset});
      $display("test float done");
      repeat (8) tst.tick(1'h1, 1'h0, t);
      repeat (8) @(negedge clk_i);
      check("tap_reset_o held", 32'h1, {31'h0, tap_reset});
      $display("test hold done");
      report_and_stop();
   end
   // about six frames of forty test clocks fit well inside this span
   initial begin
      #1_000_000;
      failures++;
      report_and_stop();
   end
endmodule
`default_nettype wire
